//--- common/jfc_pkg.sv
package jfc_pkg;
  // Clock rates
  localparam int CLK_PERIOD_PS = 4000;
  localparam int OUT_PERIOD_PS = 48000;
  localparam int HALF_NOM = OUT_PERIOD_PS / (2 * CLK_PERIOD_PS);
  // Elastic store
  localparam int PTR_W = 6;
  localparam int MEM_DEPTH = 32;
  localparam logic [5:0] DEPTH_LARGE = 6'h20;
  localparam logic [5:0] DEPTH_SMALL = 6'h10;
  localparam logic [5:0] ALARM_MARGIN = 6'h02;
  localparam logic [5:0] BW_WIDE_THR = 6'h01;
  localparam logic [5:0] PTR_ONE = 6'h01;
  // Serial interface framing: rw bit, 6 address bits, 8 data bits
  localparam int DATA_W = 8;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] HDR_LAST = 4'h6;
  localparam logic [3:0] DATA_LAST = 4'h7;
  localparam logic [3:0] DATA_END = 4'h8;
  localparam logic [3:0] CMD_REG_ADDR = 4'h0;
  localparam int CMD_DEPTH_BIT = 0;
  localparam int CMD_BW_BIT = 1;
  localparam int CMD_EDGE_BIT = 2;
  localparam int CMD_BYPASS_BIT = 3;
  localparam logic [7:0] CMD_RESET = 8'h00;
  // Local register port
  localparam int REG_ADDR_W = 4;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h4;
  localparam logic [3:0] REG_LEVEL = 4'h8;
  localparam logic [3:0] REG_CMD_VIEW = 4'hC;
  localparam int EV_ALARM = 0;
  localparam int EV_OVF = 1;
  localparam int EV_UDF = 2;
  localparam int EV_W = 3;
  // Synchroniser lanes
  localparam int SY_JCLK = 0;
  localparam int SY_POS = 1;
  localparam int SY_NEG = 2;
  localparam int SY_CFG = 3;
  localparam int SY_FSS = 4;
  localparam int SY_EDGE = 5;
  localparam int SY_BWS = 6;
  localparam int SY_ADR1 = 7;
  localparam int SY_CSN = 8;
  localparam int SY_BYP = 9;
  localparam int SY_W = 10;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_HDR = 2'b01,
    SER_WDATA = 2'b11,
    SER_RDATA = 2'b10
  } jfc_ser_st_t;
endpackage

//--- core/jfc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module jfc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_ff;
      logic stable_ff;
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          meta_ff <= 1'b0;
          stable_ff <= 1'b0;
        end else begin
          meta_ff <= async_i[g];
          stable_ff <= meta_ff;
        end
      end
      assign sync_o[g] = stable_ff;
    end
  endgenerate
endmodule
`default_nettype wire

//--- core/jfc_top.sv
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Hardware mode: depth pin high 32, low 16
// - Serial data in captured on clock rise
// - Serial data out changes on clock fall
// - Config select high enables serial interface
// - Host mode takes settings from command register
// - Config select low uses discrete pins
// - Alarm high within two of empty/full
// - Alarm widens bandwidth, stops attenuation
// - Alarm held at least one output period
// - Hardware mode: bandwidth pin high wide, low narrow
// - Host mode: bandwidth pin is address bit0
// - Edge select high samples falling, else rising
// - Reset recentres store, clears command register
// - Serial out released after read completes
module jfc_top
  import jfc_pkg::*;
#(
  parameter int HALF_NOM_P = HALF_NOM
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Jittery line side
  input wire logic jittery_clk_i,
  input wire logic jittery_pos_data_i,
  input wire logic jittery_neg_data_i,
  // Mode pins, shared with serial interface in host mode
  input wire logic config_source_select_i,
  input wire logic fifo_depth_select_i,
  input wire logic sample_edge_select_i,
  input wire logic jitter_bandwidth_select_i,
  input wire logic channel_address_bit1_i,
  input wire logic serial_if_select_n_i,
  input wire logic attenuation_bypass_i,
  output logic serial_if_data_out_o,
  output logic serial_if_data_out_oe_o,
  // Smoothed side
  output logic smoothed_out_clock_o,
  output logic smoothed_pos_data_o,
  output logic smoothed_neg_data_o,
  output logic fifo_level_alarm_o,
  // Register port
  input wire logic [REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  output logic irq_o
);
  localparam logic [3:0] HALF_SEL = 4'(HALF_NOM_P);
  localparam logic [4:0] ALARM_HOLD = 5'(2 * HALF_NOM_P + 2);
  localparam int OUT_PERIOD_CYC = 2 * HALF_NOM_P;

  ////////////////////////////////////////////////////////////////////////
  logic [SY_W-1:0] s;
  jfc_sync #(.WIDTH(SY_W)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i({attenuation_bypass_i, serial_if_select_n_i, channel_address_bit1_i,
              jitter_bandwidth_select_i, sample_edge_select_i, fifo_depth_select_i,
              config_source_select_i, jittery_neg_data_i, jittery_pos_data_i,
              jittery_clk_i}),
    .sync_o(s)
  );

  logic jclk_d_ff;
  logic sclk_d_ff;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      jclk_d_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
    end else begin
      jclk_d_ff <= s[SY_JCLK];
      sclk_d_ff <= s[SY_FSS];
    end
  end

  logic host;
  logic csn;
  logic s_rise;
  logic s_fall;
  logic j_rise;
  logic j_fall;
  logic [7:0] cmd_ff;
  logic depth32;
  logic bw_wide;
  logic edge_sel;
  logic bypass;
  assign host = s[SY_CFG];
  assign csn = s[SY_CSN];
  assign s_rise = s[SY_FSS] & ~sclk_d_ff;
  assign s_fall = ~s[SY_FSS] & sclk_d_ff;
  assign j_rise = s[SY_JCLK] & ~jclk_d_ff;
  assign j_fall = ~s[SY_JCLK] & jclk_d_ff;
  // Pins lose their meaning in host mode; command bits take over
  assign depth32 = host ? cmd_ff[CMD_DEPTH_BIT] : s[SY_FSS];
  assign bw_wide = host ? cmd_ff[CMD_BW_BIT] : s[SY_BWS];
  assign edge_sel = host ? cmd_ff[CMD_EDGE_BIT] : s[SY_EDGE];
  assign bypass = host ? cmd_ff[CMD_BYPASS_BIT] : s[SY_BYP];

  ////////////////////////////////////////////////////////////////////////
  // Serial command interface
  jfc_ser_st_t ser_st_ff, nxt_ser_st;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic [6:0] hdr_ff, nxt_hdr;
  logic [7:0] dat_ff, nxt_dat;
  logic [7:0] nxt_cmd;
  logic sdo_ff, nxt_sdo;
  logic sdo_oe_ff, nxt_sdo_oe;

  function automatic logic hdr_match(input logic [6:0] h, input logic a1, input logic a0);
    hdr_match = (h[5:4] == {a1, a0}) && (h[3:0] == CMD_REG_ADDR);
  endfunction

  always_comb begin
    nxt_ser_st = ser_st_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_hdr = hdr_ff;
    nxt_dat = dat_ff;
    nxt_cmd = cmd_ff;
    nxt_sdo = sdo_ff;
    nxt_sdo_oe = sdo_oe_ff;
    if (!host || csn) begin
      nxt_ser_st = SER_IDLE;
      nxt_bit_cnt = 4'h0;
      nxt_sdo_oe = 1'b0;
    end else begin
      unique case (ser_st_ff)
        SER_IDLE: begin
          if (s_rise) begin
            nxt_hdr = {hdr_ff[5:0], s[SY_EDGE]};
            nxt_bit_cnt = CNT_ONE;
            nxt_ser_st = SER_HDR;
          end
        end
        SER_HDR: begin
          if (s_rise) begin
            nxt_hdr = {hdr_ff[5:0], s[SY_EDGE]};
            nxt_bit_cnt = bit_cnt_ff + CNT_ONE;
            if (bit_cnt_ff == HDR_LAST) begin
              nxt_bit_cnt = 4'h0;
              if (hdr_ff[5]) begin
                nxt_ser_st = SER_RDATA;
                nxt_dat = hdr_match(nxt_hdr, s[SY_ADR1], s[SY_BWS]) ? cmd_ff : 8'h00;
              end else begin
                nxt_ser_st = SER_WDATA;
              end
            end
          end
        end
        SER_WDATA: begin
          if (s_rise) begin
            nxt_dat = {dat_ff[6:0], s[SY_EDGE]};
            nxt_bit_cnt = bit_cnt_ff + CNT_ONE;
            if (bit_cnt_ff == DATA_LAST) begin
              nxt_ser_st = SER_IDLE;
              nxt_bit_cnt = 4'h0;
              if (hdr_match(hdr_ff, s[SY_ADR1], s[SY_BWS])) begin
                nxt_cmd = nxt_dat;
              end
            end
          end
        end
        SER_RDATA: begin
          if (s_fall) begin
            if (bit_cnt_ff == DATA_END) begin
              nxt_sdo_oe = 1'b0;
              nxt_ser_st = SER_IDLE;
              nxt_bit_cnt = 4'h0;
            end else begin
              nxt_sdo = dat_ff[DATA_W-1];
              nxt_dat = {dat_ff[6:0], 1'b0};
              nxt_sdo_oe = 1'b1;
              nxt_bit_cnt = bit_cnt_ff + CNT_ONE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ser_st_ff <= SER_IDLE;
      bit_cnt_ff <= 4'h0;
      hdr_ff <= 7'h00;
      dat_ff <= 8'h00;
      cmd_ff <= CMD_RESET;
      sdo_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end else begin
      ser_st_ff <= nxt_ser_st;
      bit_cnt_ff <= nxt_bit_cnt;
      hdr_ff <= nxt_hdr;
      dat_ff <= nxt_dat;
      cmd_ff <= nxt_cmd;
      sdo_ff <= nxt_sdo;
      sdo_oe_ff <= nxt_sdo_oe;
    end
  end
  assign serial_if_data_out_o = sdo_ff;
  assign serial_if_data_out_oe_o = sdo_oe_ff;

  ////////////////////////////////////////////////////////////////////////
  // Elastic store and smoothed clock
  logic [1:0] mem [MEM_DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic recenter_ff, nxt_recenter, depth32_d_ff;
  logic [3:0] div_ff, nxt_div, half_sel;
  logic oclk_ff, nxt_oclk, opos_ff, nxt_opos, oneg_ff, nxt_oneg;
  logic [4:0] alarm_cnt_ff, nxt_alarm_cnt;
  logic alarm_ff, nxt_alarm;
  logic [PTR_W-1:0] level, depth, centre, thr;
  logic near, tick, o_rise, o_fall, wr_ev, rd_ev, wr_do, ovf, udf;

  always_comb begin
    level = wr_ptr_ff - rd_ptr_ff;
    depth = depth32 ? DEPTH_LARGE : DEPTH_SMALL;
    centre = depth >> 1;
    near = !bypass && !recenter_ff &&
           ((level <= ALARM_MARGIN) || (level >= depth - ALARM_MARGIN));
    // Alarm forces the fastest correction, giving up attenuation
    thr = (bw_wide || near) ? BW_WIDE_THR : (depth >> 2);
    if (level > centre + thr) begin
      half_sel = HALF_SEL - 4'h1;
    end else if (level + thr < centre) begin
      half_sel = HALF_SEL + 4'h1;
    end else begin
      half_sel = HALF_SEL;
    end
    tick = (div_ff >= half_sel - 4'h1);
    nxt_div = tick ? 4'h0 : div_ff + 4'h1;
    o_rise = tick & ~oclk_ff;
    o_fall = tick & oclk_ff;
    wr_ev = edge_sel ? j_fall : j_rise;
    rd_ev = edge_sel ? o_rise : o_fall;
    nxt_oclk = tick ? ~oclk_ff : oclk_ff;
    nxt_opos = opos_ff;
    nxt_oneg = oneg_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_recenter = 1'b0;
    wr_do = 1'b0;
    ovf = 1'b0;
    udf = 1'b0;
    if (bypass) begin
      nxt_oclk = s[SY_JCLK];
      nxt_opos = s[SY_POS];
      nxt_oneg = s[SY_NEG];
      nxt_recenter = 1'b1;
    end else if (recenter_ff || depth32 != depth32_d_ff) begin
      nxt_wr_ptr = rd_ptr_ff + centre;
    end else begin
      if (wr_ev) begin
        if (level < depth) begin
          wr_do = 1'b1;
          nxt_wr_ptr = wr_ptr_ff + PTR_ONE;
        end else begin
          ovf = 1'b1;
        end
      end
      if (rd_ev) begin
        if (level != 6'h00) begin
          {nxt_opos, nxt_oneg} = mem[rd_ptr_ff[4:0]];
          nxt_rd_ptr = rd_ptr_ff + PTR_ONE;
        end else begin
          udf = 1'b1;
        end
      end
    end
    // Stretch so a short excursion still spans a whole output period
    nxt_alarm_cnt = near ? ALARM_HOLD : (alarm_cnt_ff != 5'h00 ? alarm_cnt_ff - 5'h01 : 5'h00);
    nxt_alarm = near || (alarm_cnt_ff != 5'h00);
  end

  always_ff @(posedge ref_clk_i) begin
    if (wr_do) begin
      mem[wr_ptr_ff[4:0]] <= {s[SY_POS], s[SY_NEG]};
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_ff <= 6'h00;
      rd_ptr_ff <= 6'h00;
      recenter_ff <= 1'b1;
      depth32_d_ff <= 1'b0;
      div_ff <= 4'h0;
      oclk_ff <= 1'b0;
      opos_ff <= 1'b0;
      oneg_ff <= 1'b0;
      alarm_cnt_ff <= 5'h00;
      alarm_ff <= 1'b0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      recenter_ff <= nxt_recenter;
      depth32_d_ff <= depth32;
      div_ff <= nxt_div;
      oclk_ff <= nxt_oclk;
      opos_ff <= nxt_opos;
      oneg_ff <= nxt_oneg;
      alarm_cnt_ff <= nxt_alarm_cnt;
      alarm_ff <= nxt_alarm;
    end
  end
  assign smoothed_out_clock_o = oclk_ff;
  assign smoothed_pos_data_o = opos_ff;
  assign smoothed_neg_data_o = oneg_ff;
  assign fifo_level_alarm_o = alarm_ff;

  ////////////////////////////////////////////////////////////////////////
  // Status, mask and interrupt
  logic [EV_W-1:0] status_ff, nxt_status, mask_ff, nxt_mask;
  logic [7:0] rdata_ff, nxt_rdata;
  logic irq_ff, nxt_irq;

  always_comb begin
    nxt_mask = (reg_we_i && reg_addr_i == REG_MASK) ? reg_wdata_i[EV_W-1:0] : mask_ff;
    // A new event in the reading cycle survives the clear
    nxt_status = (reg_re_i && reg_addr_i == REG_STATUS) ? '0 : status_ff;
    nxt_status[EV_ALARM] = nxt_status[EV_ALARM] | (nxt_alarm & ~alarm_ff);
    nxt_status[EV_OVF] = nxt_status[EV_OVF] | ovf;
    nxt_status[EV_UDF] = nxt_status[EV_UDF] | udf;
    nxt_irq = |(nxt_status & nxt_mask);
    nxt_rdata = 8'h00;
    if (reg_re_i) begin
      unique case (reg_addr_i)
        REG_STATUS: nxt_rdata = {5'h00, status_ff};
        REG_MASK: nxt_rdata = {5'h00, mask_ff};
        REG_LEVEL: nxt_rdata = {host, bypass, level};
        REG_CMD_VIEW: nxt_rdata = cmd_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_ff <= '0;
      mask_ff <= '0;
      rdata_ff <= 8'h00;
      irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end
  assign reg_rdata_o = rdata_ff;
  assign irq_o = irq_ff;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] alarm_run_ff;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      alarm_run_ff <= 8'h00;
    end else if (!alarm_ff) begin
      alarm_run_ff <= 8'h00;
    end else if (alarm_run_ff != 8'hFF) begin
      alarm_run_ff <= alarm_run_ff + 8'h01;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_depth_small: assert property (!depth32 && $past(!depth32) && !recenter_ff
                                  |-> level <= DEPTH_SMALL)
    else $error("level beyond small depth");
  a_sdi_rise: assert property ($changed(hdr_ff) |-> $past(s_rise))
    else $error("header shifted without serial clock rise");
  a_sdo_fall: assert property ($changed(serial_if_data_out_o) |-> $past(s_fall))
    else $error("serial out changed off falling edge");
  a_sdo_host: assert property (serial_if_data_out_oe_o |-> $past(host && !csn))
    else $error("serial out driven outside host mode");
  a_cmd_hw: assert property (!host |=> $stable(cmd_ff))
    else $error("command register changed in hardware mode");
  a_alarm_level: assert property (near |=> fifo_level_alarm_o)
    else $error("alarm missing near empty or full");
  a_alarm_wide: assert property (near && level > centre + BW_WIDE_THR
                                 |-> half_sel == HALF_SEL - 4'h1)
    else $error("no fast correction during alarm");
  a_alarm_hold: assert property ($fell(fifo_level_alarm_o)
                                 |-> $past(alarm_run_ff) >= OUT_PERIOD_CYC)
    else $error("alarm pulse shorter than output period");
  // A recentre may land one ahead by chance; only line writes count here
  a_wr_edge: assert property ($past(!recenter_ff && depth32 == depth32_d_ff)
                              && wr_ptr_ff == $past(wr_ptr_ff) + PTR_ONE
                              |-> $past(edge_sel ? j_fall : j_rise))
    else $error("write on wrong line clock edge");
  a_recentre: assert property (recenter_ff && !bypass && $stable(depth32)
                               |=> level == $past(centre))
    else $error("store not recentred");
  sequence s_last_fall;
    ser_st_ff == SER_RDATA && s_fall && bit_cnt_ff == DATA_END;
  endsequence
  a_sdo_release: assert property (s_last_fall |=> !serial_if_data_out_oe_o)
    else $error("serial out not released");
endmodule
`default_nettype wire

//--- test/jfc_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module jfc_line_model (
  // Control from the bench
  input wire logic run_i,
  input wire logic fall_sample_i,
  input wire logic pos_i,
  input wire logic neg_i,
  // Line side towards the block
  output logic line_clk_o,
  output logic line_pos_o,
  output logic line_neg_o
);
  // Odd start offset keeps the line clock unrelated to the block clock
  initial begin
    line_clk_o = 1'b0;
    line_pos_o = 1'b0;
    line_neg_o = 1'b0;
    #1.3;
    forever begin
      if (run_i) begin
        #24 line_clk_o = ~line_clk_o;
        // Data moves on the edge opposite the sampling one
        if (line_clk_o == fall_sample_i) begin
          line_pos_o = pos_i;
          line_neg_o = neg_i;
        end
      end else begin
        #4;
      end
    end
  end
endmodule
`default_nettype wire

//--- test/jfc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module jfc_top_tb;
  import jfc_pkg::*;
  logic clk, rst, jclk, jpos, jneg, cfg, fifo_depth_select, edg, jitter_bandwidth_select, adr1, csn, byp;
  logic serial_if_data_out, sdo_oe, oclk, opos, oneg, alarm, we, re, irq, run, ppos, pneg;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, q, v;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;

  jfc_top i_dut (.ref_clk_i(clk), .rst_i(rst), .jittery_clk_i(jclk),
    .jittery_pos_data_i(jpos), .jittery_neg_data_i(jneg), .config_source_select_i(cfg),
    .fifo_depth_select_i(fifo_depth_select), .sample_edge_select_i(edg),
    .jitter_bandwidth_select_i(jitter_bandwidth_select), .channel_address_bit1_i(adr1),
    .serial_if_select_n_i(csn), .attenuation_bypass_i(byp), .serial_if_data_out_o(serial_if_data_out),
    .serial_if_data_out_oe_o(sdo_oe), .smoothed_out_clock_o(oclk),
    .smoothed_pos_data_o(opos), .smoothed_neg_data_o(oneg), .fifo_level_alarm_o(alarm),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .irq_o(irq));

  jfc_line_model i_line (.run_i(run), .fall_sample_i(edg), .pos_i(ppos), .neg_i(pneg),
    .line_clk_o(jclk), .line_pos_o(jpos), .line_neg_o(jneg));

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask

  // Serial frame: levels of 6 cycles leave room for the pin synchronisers
  task automatic ser(input logic rw, input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    logic [14:0] bits;
    bits = {rw, a, d};
    r = 8'h00;
    @(posedge clk);
    csn <= 1'b0;
    cyc(6);
    for (int k = 0; k < 15; k++) begin
      fifo_depth_select <= 1'b0;
      edg <= bits[14-k];
      cyc(6);
      if (k >= 7) r = {r[6:0], serial_if_data_out};
      fifo_depth_select <= 1'b1;
      cyc(6);
    end
    if (rw) chk({7'h00, sdo_oe}, 8'h01);
    fifo_depth_select <= 1'b0;
    cyc(8);
    if (rw) chk({7'h00, sdo_oe}, 8'h00);
    csn <= 1'b1;
    cyc(6);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end

  initial begin
    {rst, cfg, fifo_depth_select, edg, jitter_bandwidth_select, adr1, csn, byp} = 8'h82;
    {we, re, addr, wdata} = '0;
    {run, ppos, pneg} = 3'b110;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(REG_CMD_VIEW, v);
    chk(v, 8'h00);
    rd(4'h2, v);
    chk(v, 8'h00);
    rd(REG_LEVEL, v);
    chk({6'h00, v[7:6]}, 8'h00);
    // Equal line and output rates keep the level near the centre
    fifo_depth_select <= 1'b0;
    cyc(100);
    rd(REG_LEVEL, v);
    chk({7'h00, v[5:0] >= 6'h06 && v[5:0] <= 6'h0a}, 8'h01);
    fifo_depth_select <= 1'b1;
    cyc(100);
    rd(REG_LEVEL, v);
    chk({7'h00, v[5:0] >= 6'h0e && v[5:0] <= 6'h12}, 8'h01);
    for (int e = 0; e < 2; e++) begin
      edg <= e[0];
      ppos <= 1'b1;
      pneg <= 1'b0;
      cyc(400);
      chk({6'h00, opos, oneg}, 8'h02);
      ppos <= 1'b0;
      pneg <= 1'b1;
      cyc(400);
      chk({6'h00, opos, oneg}, 8'h01);
    end
    wr(REG_MASK, 8'h07);
    rd(REG_MASK, v);
    chk(v, 8'h07);
    // Line stops: the store drains towards empty
    run <= 1'b0;
    for (n = 0; n < 1000 && alarm !== 1'b1; n++) cyc(1);
    chk({7'h00, alarm}, 8'h01);
    cyc(2);
    chk({7'h00, irq}, 8'h01);
    rd(REG_LEVEL, v);
    chk({7'h00, v[5:0] <= 6'h02}, 8'h01);
    rd(REG_STATUS, v);
    chk({7'h00, v[0]}, 8'h01);
    cyc(100);
    rd(REG_STATUS, v);
    chk({6'h00, v[2], v[0]}, 8'h02);
    run <= 1'b1;
    for (n = 0; n < 2000 && alarm === 1'b1; n++) cyc(1);
    chk({7'h00, n >= 2 * HALF_NOM && n < 2000}, 8'h01);
    wr(REG_MASK, 8'h00);
    rd(REG_STATUS, v);
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    byp <= 1'b1;
    cyc(10);
    rd(REG_LEVEL, v);
    chk({5'h00, v[7:6], alarm}, 8'h02);
    @(posedge jclk);
    cyc(5);
    chk({7'h00, oclk}, 8'h01);
    @(negedge jclk);
    cyc(5);
    chk({7'h00, oclk}, 8'h00);
    byp <= 1'b0;
    cfg <= 1'b1;
    jitter_bandwidth_select <= 1'b1;
    cyc(10);
    rd(REG_LEVEL, v);
    chk({7'h00, v[7]}, 8'h01);
    ser(1'b0, 6'h10, 8'h0a, q);
    rd(REG_CMD_VIEW, v);
    chk(v, 8'h0a);
    rd(REG_LEVEL, v);
    chk({7'h00, v[6]}, 8'h01);
    ser(1'b1, 6'h10, 8'h00, q);
    chk(q, 8'h0a);
    ser(1'b0, 6'h20, 8'h05, q);
    rd(REG_CMD_VIEW, v);
    chk(v, 8'h0a);
    ser(1'b1, 6'h20, 8'h00, q);
    chk(q, 8'h00);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    rd(REG_CMD_VIEW, v);
    chk(v, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
